// ===== dual_port_mailbox_arbiter_tb.sv
// Self-checking bench for the left-port controller against a behavioural dual-port memory.
// Assumes the memory model stands for the device and the right port is played by its tasks.
module dual_port_mailbox_arbiter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mailbox_pkg::*;
   logic              ref_clk = 1'b0;
   logic              rst = 1'b1;
   logic [3:0]        reg_addr = '0;
   logic [31:0]       reg_wdata = '0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [31:0]       reg_rdata, st;
   logic [ADDR_W-1:0] mem_addr, a;
   logic [DATA_W-1:0] mem_dout, mem_din, got, rgot, d0, d1;
   logic              dout_oe, ce_n, we_n, oe_n, sem_n, irq_n, cont_n;
   logic [3:0]        lane_enable_n;
   logic [2:0]        idx;
   int                n_mismatch = 0;
   int                cmp_count = 0;
   int                cycles = 0;
   int                seed = 13;
   int                owner = 0;
   int                n, s, v;
   bit   [2:1]        req = '0;
   int                ops [16] = '{2, 4, 3, 2, 5, 3, 4, 5, 2, 3, 2, 4, 5, 3, 4, 5};
   mailbox_port_ctrl #(.ADDR_BITS(17), .IS_LEFT(1'b1)) DUT (.ref_clk(ref_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_dout(mem_dout), .mem_dout_oe(dout_oe),
      .mem_din(mem_din), .chip_enable_n(ce_n), .write_n(we_n), .output_enable_n(oe_n),
      .flag_space_select_n(sem_n), .lane_enable_n(lane_enable_n), .own_mailbox_irq_n(irq_n),
      .contention_flag_n(cont_n));
   dual_port_memory_model far_side (.mem_addr(mem_addr), .mem_dout(mem_dout), .chip_enable_n(ce_n),
      .write_n(we_n), .output_enable_n(oe_n), .flag_space_select_n(sem_n), .mem_din(mem_din),
      .left_mailbox_irq_n(irq_n), .left_contention_flag_n(cont_n));
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   // While a strobe is low all lanes are enabled and data is driven only for writes
   always @(negedge ref_clk) begin
      if (!rst && (!we_n || !oe_n)) begin
         chk(36'({lane_enable_n, dout_oe}), 36'({4'h0, !we_n}));
      end
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= ad;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask
   task automatic stat();
      repeat (8) @(posedge ref_clk);
      rd(OFF_STATUS, st);
   endtask
   // One memory cycle; st keeps the status seen when it finished
   task automatic cyc(input logic sm, input logic w, input logic [ADDR_W-1:0] ad,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      logic [31:0] lo, hi;
      int          k;
      wr(OFF_ADDR, 32'(ad));
      wr(OFF_WDATA_LO, d[31:0]);
      wr(OFF_WDATA_HI, {28'h0, d[35:32]});
      wr(OFF_CTRL, {29'h0, sm, w, 1'b1});
      k = 0;
      st = 32'h1;
      while (st[STAT_BUSY_BIT] !== 1'b0 && k < 50) begin
         rd(OFF_STATUS, st);
         k++;
      end
      rd(OFF_RDATA_LO, lo);
      rd(OFF_RDATA_HI, hi);
      q = {hi[3:0], lo};
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      n = 0;
      st = '0;
      while (st[STAT_INIT_BIT] !== 1'b1 && n < 100) begin
         rd(OFF_STATUS, st);
         n++;
      end
      stat();
      chk(36'(st[STAT_IRQ_BIT]), 36'h0);
      far_side.right_read(MBOX_RIGHT_ADDR, rgot);
      $display("test init done");
      d0 = 36'({$random(seed), $random(seed)});
      far_side.right_write(MBOX_LEFT_ADDR, d0);
      stat();
      chk(36'(st[STAT_IRQ_BIT]), 36'h1);
      cyc(1'b0, 1'b0, MBOX_LEFT_ADDR, '0, got);
      chk(got, d0);
      stat();
      chk(36'(st[STAT_IRQ_BIT]), 36'h0);
      d1 = 36'({$random(seed), $random(seed)});
      cyc(1'b0, 1'b1, MBOX_RIGHT_ADDR, d1, got);
      chk(36'(far_side.right_mailbox_irq_n), 36'h0);
      far_side.right_read(MBOX_RIGHT_ADDR, rgot);
      chk(rgot, d1);
      chk(36'(far_side.right_mailbox_irq_n), 36'h1);
      $display("test mailbox done");
      a = 17'($random(seed) & 32'h3ff);
      cyc(1'b0, 1'b1, a, d0, got);
      far_side.r_addr = a;
      far_side.r_ce_n = 1'b0;
      cyc(1'b0, 1'b1, a, d1, got);
      chk(36'(st[STAT_BLOCK_BIT]), 36'h1);
      far_side.r_ce_n = 1'b1;
      cyc(1'b0, 1'b0, a, '0, got);
      chk(got, d0);
      cyc(1'b0, 1'b1, a, d1, got);
      chk(36'(st[STAT_BLOCK_BIT]), 36'h0);
      cyc(1'b0, 1'b0, a, '0, got);
      chk(got, d1);
      far_side.slave = 1'b1;
      far_side.ext_busy_n = 1'b0;
      cyc(1'b0, 1'b1, a, d0, got);
      chk(36'(st[STAT_BLOCK_BIT]), 36'h1);
      cyc(1'b0, 1'b0, a, '0, got);
      chk(got, d1);
      far_side.ext_busy_n = 1'b1;
      far_side.slave = 1'b0;
      $display("test contention done");
      idx = 3'($random(seed));
      foreach (ops[k]) begin
         s = ops[k] / 2;
         v = ops[k] % 2;
         if (v == 0 && owner == 0) owner = s;
         else if (v == 0 && owner != s) req[s] = 1'b1;
         else if (v == 1 && owner == s) begin
            owner = req[3-s] ? 3 - s : 0;
            req[3-s] = 1'b0;
         end else if (v == 1) req[s] = 1'b0;
         if (s == 1) cyc(1'b1, 1'b1, 17'(idx), 36'(v), got);
         else far_side.right_sem(idx, v[0], 1'b1, rgot);
         cyc(1'b1, 1'b0, 17'(idx), '0, got);
         chk(got, {DATA_W{owner != 1}});
         chk(36'(st[STAT_TOKEN_BIT]), 36'(owner == 1));
         far_side.right_sem(idx, 1'b0, 1'b0, rgot);
         chk(rgot, {DATA_W{owner != 2}});
      end
      $display("test semaphore done");
      conclude();
   end
endmodule

// ===== dual_port_memory_model.sv
// Behavioural dual-port memory: mailboxes, master contention logic and eight semaphores.
// Assumes the controller sits on the left port; the bench plays the right port by task calls.
module dual_port_memory_model (
   input  wire logic [mailbox_pkg::ADDR_W-1:0] mem_addr,
   input  wire logic [mailbox_pkg::DATA_W-1:0] mem_dout,
   input  wire logic                           chip_enable_n,
   input  wire logic                           write_n,
   input  wire logic                           output_enable_n,
   input  wire logic                           flag_space_select_n,
   output logic      [mailbox_pkg::DATA_W-1:0] mem_din,
   output logic                                left_mailbox_irq_n,
   output logic                                left_contention_flag_n
);
   import mailbox_pkg::*;
   logic [DATA_W-1:0] store [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] sem_latch = '0;
   logic [DATA_W-1:0] last = '0;
   logic              right_mailbox_irq_n = 1'b0;
   logic [ADDR_W-1:0] r_addr = '0;
   logic              r_ce_n = 1'b1;
   // Slave role: the contention pin follows the board level only
   bit                slave = 1'b0;
   logic              ext_busy_n = 1'b1;
   int                owner [8];
   bit   [2:1]        req [8];
   // Power-on flag state is undefined, so both start asserted
   initial left_mailbox_irq_n = 1'b0;
   function automatic logic [DATA_W-1:0] peek(input logic [ADDR_W-1:0] a);
      return store.exists(a) ? store[a] : '0;
   endfunction
   function automatic void sem_wr(input int s, input logic v, input logic [2:0] i);
      if (!v) begin
         if (owner[i] == 0) owner[i] = s;
         else if (owner[i] != s) req[i][s] = 1'b1;
      end else if (owner[i] == s) begin
         owner[i] = req[i][3-s] ? 3 - s : 0;
         req[i][3-s] = 1'b0;
      end else req[i][s] = 1'b0;
   endfunction
   // Right port is always set up first, so a match flags the left port only
   assign left_contention_flag_n = slave ? ext_busy_n
                                         : !(!chip_enable_n && !r_ce_n && mem_addr == r_addr);
   // Full-depth part: all 17 address bits take part in the match
   always @(posedge write_n) begin
      if (!chip_enable_n && left_contention_flag_n) begin
         store[mem_addr] = mem_dout;
         if (mem_addr == MBOX_RIGHT_ADDR) right_mailbox_irq_n = 1'b0;
      end else if (!flag_space_select_n) sem_wr(1, mem_dout[0], mem_addr[2:0]);
   end
   always @(negedge output_enable_n) begin
      if (!chip_enable_n && mem_addr == MBOX_LEFT_ADDR) left_mailbox_irq_n = 1'b1;
      sem_latch = {DATA_W{owner[mem_addr[2:0]] != 1}};
   end
   // Released bus shows the inverse of the last value
   always @* begin
      if (!output_enable_n && !chip_enable_n) mem_din = peek(mem_addr);
      else if (!output_enable_n && !flag_space_select_n) mem_din = sem_latch;
      else mem_din = ~last;
   end
   always @(mem_din) if (!output_enable_n) last = mem_din;
   task automatic right_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      store[a] = d;
      if (a == MBOX_LEFT_ADDR) left_mailbox_irq_n = 1'b0;
   endtask
   task automatic right_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      d = peek(a);
      if (a == MBOX_RIGHT_ADDR) right_mailbox_irq_n = 1'b1;
   endtask
   task automatic right_sem(input logic [2:0] i, input logic v, input logic w, output logic [DATA_W-1:0] d);
      if (w) sem_wr(2, v, i);
      d = {DATA_W{owner[i] != 2}};
   endtask
endmodule

// ===== mailbox_pkg.sv
// Constants shared by the dual-port memory controller and its pin sequencer.
// Assumes a single 25 MHz clock domain and an asynchronous dual-port memory outside.
package mailbox_pkg;
   localparam int          ADDR_W           = 17;
   localparam int          DATA_W           = 36;
   localparam int          SEM_COUNT        = 8;
   localparam logic [16:0] MBOX_LEFT_ADDR   = 17'h1fffe;
   localparam logic [16:0] MBOX_RIGHT_ADDR  = 17'h1ffff;
   localparam logic [16:0] MBOX_LEFT_ADDR16 = 17'h0fffe;
   localparam logic [16:0] MBOX_LEFT_ADDR15 = 17'h07ffe;
   localparam int          CLK_PERIOD_NS    = 40;
   localparam int          ACCESS_NS        = 15;
   localparam int          BUSY_SETTLE_NS   = 15;
   localparam int          ACCESS_CYC       = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int          SETTLE_CYC       = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam logic [3:0]  OFF_CTRL         = 4'h0;
   localparam logic [3:0]  OFF_ADDR         = 4'h1;
   localparam logic [3:0]  OFF_WDATA_LO     = 4'h2;
   localparam logic [3:0]  OFF_WDATA_HI     = 4'h3;
   localparam logic [3:0]  OFF_STATUS       = 4'h4;
   localparam logic [3:0]  OFF_RDATA_LO     = 4'h5;
   localparam logic [3:0]  OFF_RDATA_HI     = 4'h6;
   localparam int          CTRL_GO_BIT      = 0;
   localparam int          CTRL_WRITE_BIT   = 1;
   localparam int          CTRL_SEM_BIT     = 2;
   localparam int          STAT_BUSY_BIT    = 0;
   localparam int          STAT_IRQ_BIT     = 1;
   localparam int          STAT_BLOCK_BIT   = 2;
   localparam int          STAT_INIT_BIT    = 3;
   localparam int          STAT_TOKEN_BIT   = 4;
   typedef enum logic [4:0] {
      S_IDLE   = 5'b00001,
      S_SETUP  = 5'b00010,
      S_STROBE = 5'b00100,
      S_HOLD   = 5'b01000,
      S_DONE   = 5'b10000
   } cyc_state_e;
endpackage

// ===== mailbox_port_ctrl.sv
// One port controller for a dual-port memory with mailboxes, contention flags and semaphores.
// Assumes a plain register port from software and that the far processor runs its own port.
// Notes on behaviour
// - Controller reads own mailbox after reset to initialise the flag.
// - In slave role surrounding logic holds contention input high or low.
// - Stacked masters combine contention outputs with logical AND.
// - Semaphore access uses chip enable high and semaphore select low.
module mailbox_port_ctrl
   import mailbox_pkg::*;
#(
   parameter int          ADDR_BITS = mailbox_pkg::ADDR_W,
   parameter logic        IS_LEFT   = 1'b1
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic [3:0]                    reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [31:0]                   reg_rdata,
   output logic      [mailbox_pkg::ADDR_W-1:0] mem_addr,
   output logic      [mailbox_pkg::DATA_W-1:0] mem_dout,
   output logic                               mem_dout_oe,
   input  wire logic [mailbox_pkg::DATA_W-1:0] mem_din,
   output logic                               chip_enable_n,
   output logic                               write_n,
   output logic                               output_enable_n,
   output logic                               flag_space_select_n,
   output logic      [3:0]                    lane_enable_n,
   input  wire logic                          own_mailbox_irq_n,
   input  wire logic                          contention_flag_n
);
   import mailbox_pkg::*;

   localparam logic [16:0] TOP_MASK = 17'((18'h1 << ADDR_BITS) - 18'h1);
   // Mailbox owned by this port; the far port's mailbox is the other top word
   localparam logic [16:0] OWN_MBOX = IS_LEFT ? (MBOX_LEFT_ADDR & TOP_MASK)
                                              : (MBOX_RIGHT_ADDR & TOP_MASK);

   logic irq_lvl_n, busy_lvl_n;

   pin_sync #(.W(1), .INIT(1'b1)) u_sync_irq (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .pin_in    (own_mailbox_irq_n),
      .level_out (irq_lvl_n)
   );

   // One contention pin: stacked arrays AND their flags, slave boards hold it
   pin_sync #(.W(1), .INIT(1'b1)) u_sync_busy (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .pin_in    (contention_flag_n),
      .level_out (busy_lvl_n)
   );

   cyc_state_e            st_q, st_d;
   logic [3:0]            cnt_q, cnt_d;
   logic [16:0]           addr_q, addr_d;
   logic [35:0]           wdata_q, wdata_d;
   logic [35:0]           rdata_q, rdata_d;
   logic                  is_wr_q, is_wr_d;
   logic                  is_sem_q, is_sem_d;
   logic                  init_q, init_d;
   logic                  blocked_q, blocked_d;
   logic                  token_q, token_d;
   logic                  busy_seen_q, busy_seen_d;
   logic [31:0]           rd_q, rd_d;
   logic [16:0]           mem_addr_q, mem_addr_d;
   logic [3:0]            lane_n_q, lane_n_d;
   logic                  ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, sem_n_q, sem_n_d, doe_q, doe_d;

   always_comb begin
      st_d        = st_q;
      cnt_d       = cnt_q;
      addr_d      = addr_q;
      wdata_d     = wdata_q;
      rdata_d     = rdata_q;
      is_wr_d     = is_wr_q;
      is_sem_d    = is_sem_q;
      init_d      = init_q;
      blocked_d   = blocked_q;
      token_d     = token_q;
      busy_seen_d = busy_seen_q;
      ce_n_d      = ce_n_q;
      we_n_d      = we_n_q;
      oe_n_d      = oe_n_q;
      sem_n_d     = sem_n_q;
      doe_d       = doe_q;
      rd_d        = 32'h0;
      if (reg_wr && st_q == S_IDLE && init_q) begin
         unique case (reg_addr)
            OFF_ADDR:     addr_d        = reg_wdata[16:0] & TOP_MASK;
            OFF_WDATA_LO: wdata_d[31:0] = reg_wdata;
            OFF_WDATA_HI: wdata_d[35:32] = reg_wdata[3:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            OFF_ADDR:     rd_d = {15'h0, addr_q};
            OFF_STATUS:   rd_d = {27'h0, token_q, init_q, blocked_q, ~irq_lvl_n, st_q != S_IDLE};
            OFF_RDATA_LO: rd_d = rdata_q[31:0];
            OFF_RDATA_HI: rd_d = {28'h0, rdata_q[35:32]};
            default:      rd_d = 32'h0;
         endcase
      end
      // Pin sync lags four cycles, so keep watching through the hold phase
      if ((st_q == S_STROBE || st_q == S_HOLD) && !busy_lvl_n) begin
         busy_seen_d = 1'b1;
      end
      unique case (st_q)
         S_IDLE: begin
            if (!init_q) begin
               // Power-on flag state is undefined, so read our own mailbox first
               addr_d   = OWN_MBOX;
               is_wr_d  = 1'b0;
               is_sem_d = 1'b0;
               cnt_d    = 4'(SETTLE_CYC);
               st_d     = S_SETUP;
            end else if (reg_wr && reg_addr == OFF_CTRL && reg_wdata[CTRL_GO_BIT]) begin
               is_wr_d  = reg_wdata[CTRL_WRITE_BIT];
               is_sem_d = reg_wdata[CTRL_SEM_BIT];
               cnt_d    = 4'(SETTLE_CYC);
               st_d     = S_SETUP;
            end
            if (st_d == S_SETUP) begin
               ce_n_d    = is_sem_d;
               sem_n_d   = ~is_sem_d;
               blocked_d = 1'b0;
               busy_seen_d = 1'b0;
            end
         end
         S_SETUP: begin
            // Address and enable settle before the strobe so contention is decided first
            if (cnt_q == 4'h1) begin
               cnt_d = 4'(ACCESS_CYC);
               st_d  = S_STROBE;
               if (is_wr_q) begin
                  we_n_d = 1'b0;
                  doe_d  = 1'b1;
               end else begin
                  oe_n_d = 1'b0;
               end
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         S_STROBE: begin
            if (cnt_q == 4'h1) begin
               if (!is_wr_q) begin
                  rdata_d = mem_din;
                  if (is_sem_q) begin
                     token_d = ~mem_din[0];
                  end
               end
               we_n_d = 1'b1;
               oe_n_d = 1'b1;
               cnt_d  = 4'(SETTLE_CYC);
               st_d   = S_HOLD;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         S_HOLD: begin
            if (cnt_q == 4'h1) begin
               ce_n_d  = 1'b1;
               sem_n_d = 1'b1;
               doe_d   = 1'b0;
               st_d    = S_DONE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         S_DONE: begin
            // A write seen under contention was inhibited by the memory
            blocked_d = is_wr_q && !is_sem_q && busy_seen_q;
            init_d    = 1'b1;
            st_d      = S_IDLE;
         end
         default: st_d = S_IDLE;
      endcase
      mem_addr_d = is_sem_d ? {14'h0, addr_d[2:0]} : addr_d;
      lane_n_d   = {4{ce_n_d & sem_n_d}};
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q        <= S_IDLE;
         cnt_q       <= 4'h0;
         addr_q      <= 17'h0;
         wdata_q     <= 36'h0;
         rdata_q     <= 36'h0;
         is_wr_q     <= 1'b0;
         is_sem_q    <= 1'b0;
         init_q      <= 1'b0;
         blocked_q   <= 1'b0;
         token_q     <= 1'b0;
         busy_seen_q <= 1'b0;
         ce_n_q      <= 1'b1;
         we_n_q      <= 1'b1;
         oe_n_q      <= 1'b1;
         sem_n_q     <= 1'b1;
         doe_q       <= 1'b0;
         rd_q        <= 32'h0;
         mem_addr_q  <= 17'h0;
         lane_n_q    <= 4'hf;
      end else begin
         st_q        <= st_d;
         cnt_q       <= cnt_d;
         addr_q      <= addr_d;
         wdata_q     <= wdata_d;
         rdata_q     <= rdata_d;
         is_wr_q     <= is_wr_d;
         is_sem_q    <= is_sem_d;
         init_q      <= init_d;
         blocked_q   <= blocked_d;
         token_q     <= token_d;
         busy_seen_q <= busy_seen_d;
         ce_n_q      <= ce_n_d;
         we_n_q      <= we_n_d;
         oe_n_q      <= oe_n_d;
         sem_n_q     <= sem_n_d;
         doe_q       <= doe_d;
         rd_q        <= rd_d;
         mem_addr_q  <= mem_addr_d;
         lane_n_q    <= lane_n_d;
      end
   end

   // Semaphore writes only drive data bit 0 meaningfully; all lanes enabled
   assign mem_addr            = mem_addr_q;
   assign mem_dout            = wdata_q;
   assign mem_dout_oe         = doe_q;
   assign chip_enable_n       = ce_n_q;
   assign write_n             = we_n_q;
   assign output_enable_n     = oe_n_q;
   assign flag_space_select_n = sem_n_q;
   assign lane_enable_n       = lane_n_q;
   assign reg_rdata           = rd_q;

   property p_never_both_select;
      @(posedge ref_clk) disable iff (rst) !(ce_n_q == 1'b0 && sem_n_q == 1'b0);
   endproperty
   a_never_both_select: assert property (p_never_both_select)
      else $error("chip enable and semaphore select low together");

   sequence s_strobe_start;
      $fell(we_n_q) || $fell(oe_n_q);
   endsequence
   property p_strobe_after_settle;
      @(posedge ref_clk) disable iff (rst) s_strobe_start |-> $past(st_q) == S_SETUP;
   endproperty
   a_strobe_after_settle: assert property (p_strobe_after_settle)
      else $error("strobe began without address settle");

   property p_init_read;
      @(posedge ref_clk) disable iff (rst) (!init_q && st_q == S_SETUP) |-> addr_q == OWN_MBOX && !is_wr_q;
   endproperty
   a_init_read: assert property (p_init_read)
      else $error("initial mailbox read has wrong address");

   property p_strobe_len;
      @(posedge ref_clk) disable iff (rst) $fell(we_n_q) |-> !we_n_q [*2] ##1 we_n_q;
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("write strobe length wrong");

   property p_addr_bits;
      @(posedge ref_clk) disable iff (rst) (addr_q & ~TOP_MASK) == 17'h0;
   endproperty
   a_addr_bits: assert property (p_addr_bits)
      else $error("unimplemented address bit set");

   property p_sem_addr;
      @(posedge ref_clk) disable iff (rst) !sem_n_q |-> mem_addr[16:3] == 14'h0;
   endproperty
   a_sem_addr: assert property (p_sem_addr)
      else $error("semaphore address uses high bits");

   property p_data_drive;
      @(posedge ref_clk) disable iff (rst) !we_n_q |-> doe_q && oe_n_q;
   endproperty
   a_data_drive: assert property (p_data_drive)
      else $error("write without data drive");

   property p_read_latch;
      @(posedge ref_clk) disable iff (rst) $fell(oe_n_q) |-> !oe_n_q throughout (##[1:2] $stable(ce_n_q & sem_n_q));
   endproperty
   a_read_latch: assert property (p_read_latch)
      else $error("select dropped during read");
endmodule

// ===== pin_sync.sv
// Three-flop synchroniser with agreement filter for asynchronous pin levels.
// Assumes the pin may change at any time relative to ref_clk.
module pin_sync #(
   parameter int          W         = 1,
   parameter logic [0:0]  INIT      = 1'b1
) (
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [W-1:0]  pin_in,
   output logic      [W-1:0]  level_out
);
   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s2_q[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1_q  <= {W{INIT}};
         s2_q  <= {W{INIT}};
         s3_q  <= {W{INIT}};
         lvl_q <= {W{INIT}};
      end else begin
         s1_q  <= pin_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;
endmodule
